// ### pee_dev_model.sv
// pee_dev_model.sv: behavioural paged eeprom on the far side of the host pins
// assumes clk_sys only paces the load window and program timers
`timescale 1ns/10ps
module pee_dev_model
  import pee_pkg::*;
#(
  parameter int BLC_CYC   = 1500,
  parameter int PROG_FAST = 200,
  parameter int PROG_SLOW = 3000
) (
  input  wire logic     clk_sys,
  input  wire pee_bus_s bus,
  input  wire logic     slow,
  output logic [7:0]    dq_i,
  output logic          viol
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  pg [int];
  logic [7:0]  last_d = 8'h00;
  logic [7:0]  held   = 8'h00;
  logic [16:0] wa;
  logic [16:0] page_r = '0;
  logic        armed  = 0;
  logic        loading = 0;
  logic        tog    = 0;
  logic        en;
  logic        late;
  logic        wr;
  int          nb = 0;
  int          seen = 0;
  int          cnt = 0;
  int          prog = 0;

  // --------------------
  // pin decode
  // --------------------
  initial
  begin
    viol = 0;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  assign wr = !bus.ce_n && !bus.we_n && bus.oe_n;
  assign en = !bus.ce_n && !bus.oe_n && bus.we_n;
  // output stays invalid for the access time, so an early sample sees junk
  assign #120 late = en;

  always @(posedge wr)
  begin
    if (prog != 0 || (pg.size() != 0 && bus.addr[16:7] != page_r[16:7])) viol = 1;
    wa = bus.addr;
    armed = 1;
  end

  always @(negedge wr)
  begin
    if (armed)
    begin
      pg[wa[6:0]] = dq_i;
      page_r = wa;
      last_d = dq_i;
      nb++;
      armed = 0;
    end
  end

  always @(posedge en) if (loading || prog != 0) tog = ~tog;

  always @(bus or late or tog or held or loading or prog)
  begin
    if (bus.dq_oe) dq_i = bus.dq_o;
    else if (en && late && (loading || prog != 0)) dq_i = {~last_d[7], tog, last_d[5:0]};
    else if (en && late) dq_i = mem[bus.addr];
    else dq_i = ~held;
    if (bus.dq_oe && en && late) viol = 1;
  end

  always @(dq_i) if (bus.dq_oe || (en && late)) held = dq_i;

  always @(posedge clk_sys)
  begin
    if (nb != seen)
    begin
      seen = nb;
      loading = 1;
      cnt = 0;
    end
    else if (loading)
    begin
      cnt++;
      if (cnt >= BLC_CYC)
      begin
        loading = 0;
        prog = slow ? PROG_SLOW : PROG_FAST;
      end
    end
    else if (prog != 0)
    begin
      prog--;
      if (prog == 0)
      begin
        foreach (pg[i]) mem[{page_r[16:7], i[6:0]}] = pg[i];
        pg.delete();
      end
    end
  end
endmodule : pee_dev_model

// ### pee_host.sv
// pee_host.sv: host controller that drives a paged byte-wide eeprom through its pins
// assumes the device answers reads within the access time and programs pages by itself
`timescale 1ns/10ps
`include "pee_map.svh"
module pee_host
  import pee_pkg::*;
#(
  parameter int PROG_CYC = `PEE_TWC_CYC,
  parameter int PAGE_AW  = `PEE_PAGE_LSB
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   req_valid,
  input  wire pee_req_s               req,
  output logic                        req_ready,
  output logic [`PEE_DATA_W-1:0]      rd_data,
  output logic                        rd_valid,
  output logic                        prog_done,
  output logic                        prog_timeout,
  output pee_bus_s                    bus,
  input  wire logic [`PEE_DATA_W-1:0] dq_i
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_SCAN, ST_FETCH, ST_WLOW, ST_WHIGH, ST_POLL, ST_GAP} pee_st_e;
  localparam int CW    = $clog2(PROG_CYC + 2);
  localparam int NPAGE = 2 ** PAGE_AW;
  localparam int PW    = `PEE_ADDR_W - PAGE_AW;

  pee_st_e                  st_r, st_nxt;
  logic [PAGE_AW-1:0]       idx_r, idx_nxt;
  logic [7:0]               cnt_r, cnt_nxt;
  logic [CW-1:0]            wc_r, wc_nxt;
  logic [NPAGE-1:0]         loaded_r, loaded_nxt;
  logic [PW-1:0]            page_r, page_nxt;
  logic [`PEE_ADDR_W-1:0]   tgt_r, tgt_nxt;
  logic [`PEE_DATA_W-1:0]   last_r, last_nxt;
  logic                     wrote_r, wrote_nxt;
  pee_bus_s                 bus_nxt;
  logic                     ready_nxt, rdv_nxt, done_nxt, tmo_nxt;
  logic [`PEE_DATA_W-1:0]   rdd_nxt;
  logic [`PEE_DATA_W-1:0]   dq_s1, dq_s2, dq_s3;
  logic [`PEE_DATA_W-1:0]   mem_rd;
  logic                     take, mem_we, stable;

  function automatic pee_bus_s bus_idle(input pee_bus_s cur);
    pee_bus_s b;
    b       = cur;
    b.ce_n  = 1'b1;
    b.oe_n  = 1'b1;
    b.we_n  = 1'b1;
    b.dq_oe = 1'b0;
    return b;
  endfunction : bus_idle

  function automatic pee_bus_s bus_read(input pee_bus_s cur, input logic [`PEE_ADDR_W-1:0] a);
    pee_bus_s b;
    b       = bus_idle(cur);
    b.ce_n  = 1'b0;
    b.oe_n  = 1'b0;
    b.addr  = a;
    return b;
  endfunction : bus_read

  // --------------------------------------------------------------------------
  // data pin synchroniser: only the second and third stages are compared
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
    dq_s3 <= dq_s2;
  end
  assign stable = (dq_s2 == dq_s3) && (cnt_r >= 8'(`PEE_SMP_CYC));

  assign take   = req_valid && req_ready && (st_r == ST_IDLE);
  assign mem_we = take && (req.op == PEE_OP_LOAD);

  pee_page_mem #(.DW(`PEE_DATA_W), .AW(PAGE_AW)) u_page (
    .clk_sys (clk_sys),
    .wr_en   (mem_we),
    .wr_addr (req.addr[PAGE_AW-1:0]),
    .wr_data (req.data),
    .rd_addr (idx_r),
    .rd_data (mem_rd)
  );

  // --------------------------------------------------------------------------
  // sequencer; pins follow the state one cycle later
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt     = st_r;
    idx_nxt    = idx_r;
    cnt_nxt    = (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
    wc_nxt     = wc_r;
    loaded_nxt = loaded_r;
    page_nxt   = page_r;
    tgt_nxt    = tgt_r;
    last_nxt   = last_r;
    wrote_nxt  = wrote_r;
    bus_nxt    = bus_idle(bus);
    rdv_nxt    = 1'b0;
    rdd_nxt    = rd_data;
    done_nxt   = 1'b0;
    tmo_nxt    = 1'b0;
    unique case (st_r)
      ST_IDLE:
      begin
        cnt_nxt = 8'h00;
        if (take)
        begin
          unique case (req.op)
            PEE_OP_READ:
            begin
              tgt_nxt = req.addr;
              st_nxt  = ST_RD;
            end
            PEE_OP_LOAD:
            begin
              // a byte for another page drops the bytes staged so far
              if (req.addr[`PEE_ADDR_W-1:PAGE_AW] != page_r)
              begin
                loaded_nxt = '0;
              end
              page_nxt                          = req.addr[`PEE_ADDR_W-1:PAGE_AW];
              loaded_nxt[req.addr[PAGE_AW-1:0]] = 1'b1;
            end
            default:
            begin
              idx_nxt   = '0;
              wrote_nxt = 1'b0;
              st_nxt    = ST_SCAN;
            end
          endcase
        end
      end
      ST_RD:
      begin
        bus_nxt = bus_read(bus, tgt_r);
        if (stable)
        begin
          rdd_nxt = dq_s3;
          rdv_nxt = 1'b1;
          bus_nxt = bus_idle(bus);
          st_nxt  = ST_IDLE;
        end
      end
      ST_SCAN:
      begin
        bus_nxt      = bus_idle(bus);
        bus_nxt.oe_n = 1'b0;
        if (loaded_r[idx_r])
        begin
          st_nxt = ST_FETCH;
        end
        else if (idx_r == PAGE_AW'(NPAGE - 1))
        begin
          loaded_nxt = '0;
          wc_nxt     = '0;
          cnt_nxt    = 8'h00;
          done_nxt   = !wrote_r;
          st_nxt     = wrote_r ? ST_POLL : ST_IDLE;
        end
        else
        begin
          idx_nxt = idx_r + 1'b1;
        end
      end
      ST_FETCH:
      begin
        bus_nxt       = bus_idle(bus);
        bus_nxt.oe_n  = 1'b0;
        bus_nxt.addr  = {page_r, idx_r};
        bus_nxt.dq_o  = mem_rd;
        bus_nxt.dq_oe = 1'b1;
        cnt_nxt       = 8'h00;
        st_nxt        = ST_WLOW;
      end
      ST_WLOW:
      begin
        // select and strobe fall together so both edges of the write coincide
        bus_nxt       = bus;
        bus_nxt.ce_n  = 1'b0;
        bus_nxt.we_n  = 1'b0;
        bus_nxt.oe_n  = 1'b1;
        if (cnt_r >= 8'(`PEE_WP_CYC - 1))
        begin
          st_nxt = ST_WHIGH;
        end
      end
      ST_WHIGH:
      begin
        // data stay driven for one cycle past the rising strobe
        bus_nxt      = bus;
        bus_nxt.ce_n = 1'b1;
        bus_nxt.we_n = 1'b1;
        bus_nxt.oe_n = 1'b0;
        tgt_nxt      = bus.addr;
        last_nxt     = bus.dq_o;
        wrote_nxt    = 1'b1;
        idx_nxt      = idx_r + 1'b1;
        st_nxt       = ST_SCAN;
        if (idx_r == PAGE_AW'(NPAGE - 1))
        begin
          loaded_nxt = '0;
          wc_nxt     = '0;
          cnt_nxt    = 8'h00;
          st_nxt     = ST_POLL;
        end
      end
      ST_POLL, ST_GAP:
      begin
        // completion is seen by the true poll bit; a stuck device times out
        wc_nxt = wc_r + 1'b1;
        if (st_r == ST_POLL)
        begin
          bus_nxt = bus_read(bus, tgt_r);
          if (stable)
          begin
            cnt_nxt = 8'h00;
            st_nxt  = ST_GAP;
            if (dq_s3[`PEE_POLL_BIT] == last_r[`PEE_POLL_BIT])
            begin
              rdd_nxt  = dq_s3;
              done_nxt = 1'b1;
              st_nxt   = ST_IDLE;
            end
          end
        end
        else
        begin
          bus_nxt      = bus_read(bus, tgt_r);
          bus_nxt.oe_n = 1'b1;
          if (cnt_r >= 8'(`PEE_OEHP_CYC))
          begin
            cnt_nxt = 8'h00;
            st_nxt  = ST_POLL;
          end
        end
        // a true poll bit seen in the last counted cycle wins over the timeout
        if ((wc_r >= CW'(PROG_CYC)) && !done_nxt)
        begin
          done_nxt = 1'b1;
          tmo_nxt  = 1'b1;
          bus_nxt  = bus_idle(bus);
          st_nxt   = ST_IDLE;
        end
      end
    endcase
    ready_nxt = (st_nxt == ST_IDLE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_r         <= ST_IDLE;
      idx_r        <= '0;
      cnt_r        <= 8'h00;
      wc_r         <= '0;
      loaded_r     <= '0;
      page_r       <= '0;
      tgt_r        <= '0;
      last_r       <= 8'h00;
      wrote_r      <= 1'b0;
      bus          <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: 8'h00, dq_oe: 1'b0};
      req_ready    <= 1'b0;
      rd_data      <= 8'h00;
      rd_valid     <= 1'b0;
      prog_done    <= 1'b0;
      prog_timeout <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      idx_r        <= idx_nxt;
      cnt_r        <= cnt_nxt;
      wc_r         <= wc_nxt;
      loaded_r     <= loaded_nxt;
      page_r       <= page_nxt;
      tgt_r        <= tgt_nxt;
      last_r       <= last_nxt;
      wrote_r      <= wrote_nxt;
      bus          <= bus_nxt;
      req_ready    <= ready_nxt;
      rd_data      <= rdd_nxt;
      rd_valid     <= rdv_nxt;
      prog_done    <= done_nxt;
      prog_timeout <= tmo_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  localparam int BLC = `PEE_BLC_CYC;
  logic        wseq_r;
  logic [11:0] gap_r;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wseq_r <= 1'b0;
      gap_r  <= 12'h000;
    end
    else
    begin
      wseq_r <= (st_r == ST_FETCH) || (st_r == ST_WLOW) || (st_r == ST_WHIGH) || (st_r == ST_SCAN && wrote_r);
      gap_r  <= (bus.we_n && !bus_nxt.we_n) ? 12'h000 : ((gap_r == 12'hfff) ? gap_r : gap_r + 12'h001);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_strobe_low;
    !bus.we_n && !bus.ce_n && bus.oe_n && bus.dq_oe;
  endsequence
  sequence s_strobe_rise;
    bus.we_n && bus.ce_n && bus.dq_oe && $stable(bus.dq_o) && $stable(bus.addr);
  endsequence

  a_write_pins: assert property (!bus.we_n |-> !bus.ce_n && bus.oe_n && bus.dq_oe)
    else $error("strobe low without select low, gate high and data driven");
  a_write_pulse: assert property ($fell(bus.we_n) |-> s_strobe_low ##1 s_strobe_rise)
    else $error("write pulse shape or data hold wrong");
  a_read_float: assert property (!bus.oe_n && !bus.ce_n |-> !bus.dq_oe)
    else $error("host drives data while device is reading out");
  a_page_same: assert property (wseq_r && $fell(bus.we_n) |-> bus.addr[`PEE_ADDR_W-1:PAGE_AW] == page_r)
    else $error("page address bits changed within a page load");
  a_gate_hold: assert property (wseq_r && bus.oe_n |-> !bus.we_n && !bus.ce_n)
    else $error("gate high outside a strobe low during page load");
  a_load_window: assert property (wseq_r && (st_r == ST_FETCH) |-> gap_r < 12'(BLC))
    else $error("next page byte later than the byte load window");
  a_poll_bound: assert property ((st_r == ST_POLL) |-> wc_r <= CW'(PROG_CYC))
    else $error("polling ran past the program time");
  a_poll_end: assert property ((st_r == ST_POLL) && stable && (dq_s3[`PEE_POLL_BIT] == last_r[`PEE_POLL_BIT])
                               |=> prog_done && !prog_timeout && req_ready)
    else $error("true poll bit did not end programming");
endmodule : pee_host

// ### pee_map.svh
// pee_map.svh: pin timing counts and address field positions for the paged eeprom host port
// assumes clk_sys runs at the rate given by PEE_CLK_NS
`ifndef PEE_MAP_SVH
`define PEE_MAP_SVH

// ----------------------------------------------------------------------------
// address and data fields
// ----------------------------------------------------------------------------
`define PEE_ADDR_W      17
`define PEE_PAGE_LSB    7
`define PEE_DATA_W      8
`define PEE_POLL_BIT    7

// ----------------------------------------------------------------------------
// times as printed and derived cycle counts
// ----------------------------------------------------------------------------
`define PEE_CLK_NS      100
`define PEE_TWP_NS      100
`define PEE_TACC_NS     120
`define PEE_TOEHP_NS    150
`define PEE_TWC_MS      10
`define PEE_BYTE_LOAD_WINDOW_US     150
// least times and the access time round up, the program time and byte load window round down
`define PEE_WP_CYC      ((`PEE_TWP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_ACC_CYC     ((`PEE_TACC_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_OEHP_CYC    ((`PEE_TOEHP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_TWC_CYC     ((`PEE_TWC_MS * 1000000) / `PEE_CLK_NS)
`define PEE_BLC_CYC     ((`PEE_BYTE_LOAD_WINDOW_US * 1000) / `PEE_CLK_NS)
// pins lag state by one cycle, then three synchroniser stages
`define PEE_SMP_CYC     (`PEE_ACC_CYC + 4)

`endif

// ### pee_page_mem.sv
// pee_page_mem.sv: one page of staged bytes, one write port, one registered read port
// assumes a single clock; read data appear one cycle after the address
`timescale 1ns/10ps
module pee_page_mem #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          clk_sys,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule : pee_page_mem

// ### pee_pkg.sv
// pee_pkg.sv: types shared by the paged eeprom host port
// assumes pee_map.svh is on the include path
package pee_pkg;
  `include "pee_map.svh"

  typedef enum logic [1:0]
  {
    PEE_OP_READ,
    PEE_OP_LOAD,
    PEE_OP_PROGRAM
  } pee_op_e;

  typedef struct packed
  {
    pee_op_e                  op;
    logic [`PEE_ADDR_W-1:0]   addr;
    logic [`PEE_DATA_W-1:0]   data;
  } pee_req_s;

  typedef struct packed
  {
    logic                     ce_n;
    logic                     oe_n;
    logic                     we_n;
    logic [`PEE_ADDR_W-1:0]   addr;
    logic [`PEE_DATA_W-1:0]   dq_o;
    logic                     dq_oe;
  } pee_bus_s;

endpackage : pee_pkg

// ### testbench.sv
// testbench.sv: self-checking bench for the paged eeprom host port
// assumes pee_dev_model resolves the data pins on the far side
`timescale 1ns/10ps
module testbench;
  import pee_pkg::*;
  localparam int PROG_CYC = 2500;
  logic       clk_sys = 0;
  logic       reset_n = 0;
  logic       req_valid = 0;
  logic       slow = 0;
  pee_req_s   req = '0;
  logic       req_ready, rd_valid, prog_done, prog_timeout, viol;
  logic [7:0] rd_data, dq_i, r1, r2;
  pee_bus_s   bus;
  int         miscompares = 0;
  int         tests_run = 0;

  always #50 clk_sys = ~clk_sys;

  pee_host #(.PROG_CYC(PROG_CYC), .PAGE_AW(7)) u_pee_host (.clk_sys(clk_sys), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .prog_done(prog_done), .prog_timeout(prog_timeout), .bus(bus), .dq_i(dq_i));
  pee_dev_model u_pee_dev_model (.clk_sys(clk_sys), .bus(bus), .slow(slow), .dq_i(dq_i), .viol(viol));

  // --------------------
  // shared tasks
  // --------------------
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic fail(input string what);
    miscompares++;
    $display("MISMATCH %0t %s", $time, what);
    wrap_up();
  endtask : fail

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  task automatic send(input pee_op_e op, input logic [16:0] a, input logic [7:0] d);
    int i;
    @(negedge clk_sys);
    req_valid = 1;
    req = '{op: op, addr: a, data: d};
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 100) fail("request not taken");
    @(negedge clk_sys);
    req_valid = 0;
  endtask : send

  // slow pages run to the poll limit, which already spans the load window, hence the wide bound
  task automatic wait_done(input int which, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge clk_sys);
      if ((which == 0 ? rd_valid : prog_done) === 1'b1) break;
    end
    if (i == lim) fail("no answer");
  endtask : wait_done

  task automatic rd(input logic [16:0] a, output logic [7:0] d);
    send(PEE_OP_READ, a, 8'h00);
    wait_done(0, 200);
    d = rd_data;
  endtask : rd

  task automatic prog_chk(input logic to);
    send(PEE_OP_PROGRAM, '0, 8'h00);
    wait_done(1, 6000);
    chk1(prog_timeout, to, "timeout flag");
  endtask : prog_chk

  // --------------------
  // scenarios
  // --------------------
  task automatic t_idle();
    chk1(bus.ce_n, 1'b1, "select at idle");
    chk1(bus.dq_oe, 1'b0, "data driven at idle");
  endtask : t_idle

  task automatic t_blank();
    rd(17'h00155, r1);
    chk8(r1, 8'hff, "blank read");
    chk1(bus.oe_n, 1'b1, "gate after read");
  endtask : t_blank

  task automatic t_page();
    logic [6:0] idx [4] = '{7'd127, 7'd0, 7'd5, 7'd6};
    logic [7:0] exp [4] = '{8'ha5, 8'h3c, 8'h96, 8'hff};
    send(PEE_OP_LOAD, {10'h012, 7'd127}, 8'ha5);
    send(PEE_OP_LOAD, {10'h012, 7'd0}, 8'h3c);
    send(PEE_OP_LOAD, {10'h012, 7'd5}, 8'h11);
    send(PEE_OP_LOAD, {10'h012, 7'd5}, 8'h96);
    prog_chk(1'b0);
    foreach (idx[i])
    begin
      rd({10'h012, idx[i]}, r1);
      chk8(r1, exp[i], "page byte");
    end
  endtask : t_page

  task automatic t_discard();
    send(PEE_OP_LOAD, {10'h3ff, 7'd1}, 8'h55);
    send(PEE_OP_LOAD, {10'h001, 7'd2}, 8'h0f);
    prog_chk(1'b0);
    rd({10'h3ff, 7'd1}, r1);
    chk8(r1, 8'hff, "dropped page");
    rd({10'h001, 7'd2}, r1);
    chk8(r1, 8'h0f, "kept page");
  endtask : t_discard

  task automatic t_empty();
    send(PEE_OP_PROGRAM, '0, 8'h00);
    wait_done(1, 400);
    chk1(prog_timeout, 1'b0, "empty timeout");
    chk1(bus.ce_n, 1'b1, "empty pins");
  endtask : t_empty

  task automatic t_slow();
    int i;
    slow = 1;
    send(PEE_OP_LOAD, {10'h050, 7'd9}, 8'h2b);
    prog_chk(1'b1);
    rd({10'h050, 7'd9}, r1);
    rd({10'h050, 7'd9}, r2);
    chk1(r1[7], 1'b1, "poll bit busy");
    chk8({2'b00, r1[5:0]}, 8'h2b, "low bits busy");
    chk1(r2[6], ~r1[6], "toggle bit");
    for (i = 0; i < 1000 && r1 !== 8'h2b; i++) rd({10'h050, 7'd9}, r1);
    chk8(r1, 8'h2b, "true data");
    rd({10'h050, 7'd9}, r2);
    chk8(r2, 8'h2b, "toggle stopped");
    slow = 0;
  endtask : t_slow

  initial
  begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1;
    repeat (2) @(negedge clk_sys);
    t_idle();
    t_blank();
    t_page();
    t_discard();
    t_empty();
    t_slow();
    chk1(viol, 1'b0, "pin protocol");
    wrap_up();
  end
endmodule : testbench
